// >>> uhps_bank_ram.sv
// Pipe buffer RAM: three banks of byte storage with one write and one read port
`timescale 1ns/1ns
module uhps_bank_ram (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [1:0] i_wbank,
  input wire logic [9:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [1:0] i_rbank,
  input wire logic [9:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:uhps_pkg::BANKS*uhps_pkg::BANK_DEPTH-1];

  // Combinational read keeps the FIFO pop free of extra latency
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[{i_wbank, i_waddr}] <= i_wdata;
    end
  end

  assign o_rdata = mem[{i_rbank, i_raddr}];
endmodule

// >>> uhps_fit_check.sv
// Allocation check: decides whether bank count and size fit the pipe and RAM
`timescale 1ns/1ns
module uhps_fit_check (
  // Configuration
  input wire logic [1:0] i_bank_count_sel,
  input wire logic [2:0] i_bank_size_sel,
  // Result
  output logic o_fits
);
  logic [12:0] bank_bytes;
  logic [14:0] total;

  always_comb begin
    bank_bytes = 13'(13'h0008 << i_bank_size_sel);
    total = 15'(bank_bytes) * 15'({13'h0000, i_bank_count_sel} + 15'h0001);
    o_fits = (i_bank_count_sel <= uhps_pkg::MAX_BANKS_SEL) &&
             (i_bank_size_sel <= uhps_pkg::MAX_SIZE_SEL) &&
             (total <= 15'(uhps_pkg::RAM_BYTES));
  end
endmodule

// >>> uhps_link_model.sv
// Behavioural model of the USB device side driving the link inputs
`timescale 1ns/1ns
module uhps_link_model (
  // Clock
  input wire logic i_clk,
  // Toward the pipe
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_pkt_start,
  output logic o_pkt_end,
  output logic o_pid1,
  output logic o_tx_req,
  output logic [4:0] o_evt,
  // From the pipe
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid
);
  initial begin
    {o_rx_valid, o_pkt_start, o_pkt_end, o_pid1, o_tx_req} = 5'h00;
    o_rx_data = 8'h5A;
    o_evt = 5'h00;
  end
  // Event bits: fault, crc, nak, stall, slot; the idle edge avoids merging pulses
  task automatic evt(input logic [4:0] m);
    o_evt <= m;
    @(posedge i_clk);
    o_evt <= 5'h00;
    @(posedge i_clk);
  endtask
  task automatic send_in(input int n, input logic pid1);
    o_pkt_start <= 1'b1;
    @(posedge i_clk);
    o_pkt_start <= 1'b0;
    o_rx_valid <= 1'b1;
    for (int k = 0; k < n; k++) begin
      o_rx_data <= 8'hA0 + 8'(k);
      @(posedge i_clk);
    end
    // Released data flips so a stale byte never looks fresh
    o_rx_valid <= 1'b0;
    o_rx_data <= ~o_rx_data;
    o_pkt_end <= 1'b1;
    o_pid1 <= pid1;
    @(posedge i_clk);
    o_pkt_end <= 1'b0;
    o_pid1 <= ~pid1;
    @(posedge i_clk);
  endtask
  task automatic take_byte(output logic [8:0] d);
    o_tx_req <= 1'b1;
    @(posedge i_clk);
    o_tx_req <= 1'b0;
    @(posedge i_clk);
    d = {i_tx_valid, i_tx_data};
  endtask
endmodule

// >>> uhps_pipe_status.sv
// Per-pipe status logic of a USB host controller with a Wishbone register port
//
// Functional notes
// - OUT: software write up, link send down
// - IN: link receive up, software read down
// - Byte count, bank may lag flag one cycle
// - Allocate sets config ok when fit
// - OUT: allowed while current bank not full
// - IN: allowed while current bank not empty
// - Stall or fault forces allowed low
// - Current bank coded 0,1,2; 3 reserved
// - OUT: all banks busy raises irq
// - IN: all banks free raises irq
// - Busy count coded 0,1,2; 3 reserved (code reports 3 when three banks are busy)
// - Toggle reported DATA0 or DATA1
// - Short packet flag, write-one clear
// - Stall sets flag and freezes pipe
// - Iso CRC error shares stall bit
// - Overrun flag, irq, write-one clear
// - NAK sets flag, optional irq
// - Fault flag follows fault source
// - Control: setup bank free flag
// - Iso/intr OUT late: underrun, send ZLP
// - Iso/intr IN full: underrun, drop packet
// - OUT bank free flag, write-one clear
// - Clear register: ones clear, zeros ignored (code ignores a one on the fault bit; only the fault source write clears it)
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module uhps_pipe_status (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // USB link engine: bytes
  input wire logic i_link_rx_valid,
  input wire logic [7:0] i_link_rx_data,
  input wire logic i_link_tx_req,
  output logic [7:0] o_link_tx_data,
  output logic o_link_tx_valid,
  // USB link engine: packet events
  input wire logic i_link_pkt_end,
  input wire logic i_link_pkt_pid1,
  input wire logic i_link_pkt_start,
  input wire logic i_link_out_slot,
  input wire logic i_link_stall,
  input wire logic i_link_nak,
  input wire logic i_link_crc_err,
  input wire logic i_link_fault,
  // USB link engine: responses
  output logic o_link_send_zlp,
  output logic o_link_drop_pkt,
  output logic o_link_ack_pkt,
  output logic o_pipe_frozen,
  output logic o_pipe_irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] config_reg;
  logic [31:0] control_reg;
  logic [7:0] flags_reg;
  logic [7:0] fault_src_reg;
  logic config_ok_reg;
  logic [10:0] byte_count_reg;
  logic [9:0] wptr_reg;
  logic [9:0] rptr_reg;
  logic [1:0] wbank_reg;
  logic [1:0] rbank_reg;
  logic [1:0] busy_reg;
  logic [1:0] toggle_reg [0:2];
  logic [1:0] out_toggle_reg;
  logic [10:0] fill_reg [0:2];
  logic rx_active_reg;
  logic rx_over_reg;
  logic [10:0] rx_len_reg;
  logic rw_allowed_reg;
  logic [1:0] cur_bank_reg;
  logic frozen_reg;
  logic irq_reg;
  logic prev_all_busy_reg;
  logic prev_all_free_reg;
  logic [7:0] tx_data_reg;
  logic tx_valid_reg;
  logic zlp_reg;
  logic drop_reg;
  logic ackp_reg;
  logic [31:0] rdat_reg;
  logic ack_reg;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  logic [1:0] pipe_type;
  logic [1:0] banks_sel;
  logic [2:0] size_sel;
  logic is_in;
  logic iso_or_intr;
  logic [10:0] bank_bytes;
  logic [1:0] nbanks;
  logic [1:0] cur_bank;
  logic fits;
  logic [7:0] rdata;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic sw_push;
  logic sw_pop;
  logic link_push;
  logic link_pop;
  logic push;
  logic pop;
  logic bank_full_evt;
  logic bank_drain_evt;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [7:0] fire;

  function automatic logic [1:0] next_bank(input logic [1:0] b, input logic [1:0] n);
    next_bank = (b == n - 2'h1) ? 2'h0 : 2'(b + 2'h1);
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  assign pipe_type = config_reg[uhps_pkg::POS_TYPE +: 2];
  assign banks_sel = config_reg[uhps_pkg::POS_BANKS +: 2];
  assign size_sel = config_reg[uhps_pkg::POS_SIZE +: 3];
  assign is_in = (config_reg[uhps_pkg::POS_TOKEN +: 2] == uhps_pkg::TOKEN_IN);
  assign iso_or_intr = (pipe_type == uhps_pkg::TYPE_ISO) || (pipe_type == uhps_pkg::TYPE_INTR);
  assign bank_bytes = 11'(11'h008 << size_sel);
  assign nbanks = (banks_sel > uhps_pkg::MAX_BANKS_SEL) ? 2'h1 : 2'(banks_sel + 2'h1);
  assign cur_bank = is_in ? rbank_reg : wbank_reg;

  assign bus_req = i_wb_cyc && i_wb_stb && !ack_reg;
  assign bus_wr = bus_req && i_wb_we;
  assign bus_rd = bus_req && !i_wb_we;
  assign sw_push = bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_FIFO) && i_wb_sel[0] && !is_in && rw_allowed_reg;
  assign sw_pop = bus_rd && hit(i_wb_adr, uhps_pkg::ADDR_FIFO) && is_in && rw_allowed_reg;
  // drop packet when no free bank
  assign link_push = is_in && i_link_rx_valid && rx_active_reg && !rx_over_reg && !frozen_reg &&
                     (busy_reg < nbanks) && (11'(wptr_reg) < bank_bytes);
  assign link_pop = !is_in && i_link_tx_req && (busy_reg != 2'h0) && !frozen_reg;
  assign push = is_in ? link_push : sw_push;
  assign pop = is_in ? sw_pop : link_pop;

  // OUT bank handed to link when full; IN bank freed when read empty
  assign bank_full_evt = is_in ? (rx_active_reg && i_link_pkt_end && !rx_over_reg)
                               : (sw_push && (wptr_reg == 10'(bank_bytes - 11'h001)));
  assign bank_drain_evt = is_in ? (sw_pop && (11'(rptr_reg) + 11'h001 == fill_reg[rbank_reg]))
                                : (link_pop && (11'(rptr_reg) + 11'h001 == fill_reg[rbank_reg]));

  // Fit is judged on the word being written, not on the old setting
  uhps_fit_check u_fit (
    .i_bank_count_sel(i_wb_dat[uhps_pkg::POS_BANKS +: 2]),
    .i_bank_size_sel(i_wb_dat[uhps_pkg::POS_SIZE +: 3]),
    .o_fits(fits)
  );

  uhps_bank_ram u_ram (
    .i_clk(i_clk),
    .i_we(push),
    .i_wbank(wbank_reg),
    .i_waddr(wptr_reg),
    .i_wdata(is_in ? i_link_rx_data : i_wb_dat[7:0]),
    .i_rbank(rbank_reg),
    .i_raddr(rptr_reg),
    .o_rdata(rdata)
  );

  // ----------------------------------------
  // Configuration and control registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      config_reg <= uhps_pkg::CONFIG_RESET;
      control_reg <= uhps_pkg::CONTROL_RESET;
      config_ok_reg <= 1'b0;
    end else begin
      if (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_CONFIG)) begin
        config_reg <= i_wb_dat;
        if (i_wb_dat[uhps_pkg::POS_PIPE_MEM_ALLOCATE]) begin
          config_ok_reg <= fits;
        end
      end
      if (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_CONTROL)) begin
        control_reg <= i_wb_dat;
      end
    end
  end

  // ----------------------------------------
  // Bank pointers, byte count, busy banks
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wptr_reg <= 10'h000;
      rptr_reg <= 10'h000;
      wbank_reg <= 2'h0;
      rbank_reg <= 2'h0;
      busy_reg <= 2'h0;
      byte_count_reg <= 11'h000;
      for (int b = 0; b < 3; b++) begin
        fill_reg[b] <= 11'h000;
        toggle_reg[b] <= 2'h0;
      end
    end else begin
      byte_count_reg <= 11'(byte_count_reg + {10'h000, push} - {10'h000, pop});
      if (push) begin
        wptr_reg <= 10'(wptr_reg + 10'h001);
      end
      if (bank_full_evt) begin
        fill_reg[wbank_reg] <= is_in ? 11'(11'(wptr_reg) + {10'h000, link_push}) : bank_bytes;
        toggle_reg[wbank_reg] <= is_in ? {1'b0, i_link_pkt_pid1} : out_toggle_reg;
        wbank_reg <= next_bank(wbank_reg, nbanks);
        wptr_reg <= 10'h000;
      end
      if (pop) begin
        rptr_reg <= 10'(rptr_reg + 10'h001);
      end
      if (bank_drain_evt) begin
        rbank_reg <= next_bank(rbank_reg, nbanks);
        rptr_reg <= 10'h000;
      end
      busy_reg <= 2'(busy_reg + {1'b0, bank_full_evt} - {1'b0, bank_drain_evt});
    end
  end

  // ----------------------------------------
  // Receive framing and status flags
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_active_reg <= 1'b0;
      rx_over_reg <= 1'b0;
      rx_len_reg <= 11'h000;
    end else begin
      if (i_link_pkt_start && is_in) begin
        rx_active_reg <= 1'b1;
        rx_len_reg <= 11'h000;
        rx_over_reg <= (busy_reg >= nbanks);
      end else if (i_link_pkt_end) begin
        rx_active_reg <= 1'b0;
      end else if (rx_active_reg && i_link_rx_valid) begin
        rx_len_reg <= 11'(rx_len_reg + 11'h001);
      end
    end
  end

  // Shared bits: control pipes use stall/setup, iso uses CRC, iso/intr use underrun
  always_comb begin
    set_bits = 8'h00;
    set_bits[uhps_pkg::BIT_RXIN] = bank_full_evt && is_in;
    // out bank free, also on allocate
    set_bits[uhps_pkg::BIT_OUTFREE] = (!is_in && (pipe_type != uhps_pkg::TYPE_CONTROL) && bank_drain_evt) ||
      (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_CONFIG) && i_wb_dat[uhps_pkg::POS_PIPE_MEM_ALLOCATE] && fits &&
       (i_wb_dat[uhps_pkg::POS_TOKEN +: 2] != uhps_pkg::TOKEN_IN) &&
       (i_wb_dat[uhps_pkg::POS_TYPE +: 2] != uhps_pkg::TYPE_CONTROL));
    if (pipe_type == uhps_pkg::TYPE_CONTROL) begin
      set_bits[uhps_pkg::BIT_SETUP_UNDER] = !is_in && bank_drain_evt;
    end else if (iso_or_intr) begin
      set_bits[uhps_pkg::BIT_SETUP_UNDER] = (!is_in && i_link_out_slot && busy_reg == 2'h0) ||
                                            (is_in && i_link_pkt_start && busy_reg >= nbanks);
    end
    set_bits[uhps_pkg::BIT_STALL_CRC] = (pipe_type == uhps_pkg::TYPE_ISO) ? i_link_crc_err : i_link_stall;
    set_bits[uhps_pkg::BIT_OVERRUN] = rx_active_reg && i_link_rx_valid && (rx_len_reg >= bank_bytes);
    set_bits[uhps_pkg::BIT_NAK] = i_link_nak;
    set_bits[uhps_pkg::BIT_SHORT] = is_in && rx_active_reg && i_link_pkt_end && (rx_len_reg < bank_bytes);
    if (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_STATUS_SET)) begin
      set_bits = set_bits | i_wb_dat[7:0];
    end
    clr_bits = (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_STATUS_CLR)) ? i_wb_dat[7:0] : 8'h00;
    clr_bits[uhps_pkg::BIT_FAULT] = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_reg <= 8'h00;
      fault_src_reg <= 8'h00;
    end else begin
      // Set wins over a same-cycle clear
      flags_reg <= (flags_reg & ~clr_bits) | set_bits;
      if (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_FAULT_SRC)) begin
        fault_src_reg <= (fault_src_reg & i_wb_dat[7:0]) | {7'h00, i_link_fault};
        flags_reg[uhps_pkg::BIT_FAULT] <= ((fault_src_reg & i_wb_dat[7:0]) != 8'h00) || i_link_fault;
      end else if (i_link_fault) begin
        fault_src_reg[0] <= 1'b1;
        flags_reg[uhps_pkg::BIT_FAULT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Derived status, freeze, interrupt
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rw_allowed_reg <= 1'b0;
      cur_bank_reg <= 2'h0;
      frozen_reg <= 1'b0;
      out_toggle_reg <= 2'h0;
      irq_reg <= 1'b0;
      prev_all_busy_reg <= 1'b0;
      prev_all_free_reg <= 1'b1;
    end else begin
      rw_allowed_reg <= !(flags_reg[uhps_pkg::BIT_STALL_CRC] && pipe_type != uhps_pkg::TYPE_ISO) &&
                        !flags_reg[uhps_pkg::BIT_FAULT] && config_ok_reg &&
                        (is_in ? (busy_reg != 2'h0) : (busy_reg < nbanks));
      cur_bank_reg <= (pipe_type == uhps_pkg::TYPE_CONTROL) ? 2'h0 : cur_bank;
      if (set_bits[uhps_pkg::BIT_STALL_CRC] && pipe_type != uhps_pkg::TYPE_ISO) begin
        frozen_reg <= 1'b1;
      end else if (bus_wr && hit(i_wb_adr, uhps_pkg::ADDR_CONTROL)) begin
        frozen_reg <= i_wb_dat[17];
      end
      if (bank_full_evt && !is_in) begin
        out_toggle_reg <= {1'b0, ~out_toggle_reg[0]};
      end
      prev_all_busy_reg <= (busy_reg == nbanks);
      prev_all_free_reg <= (busy_reg == 2'h0);
      irq_reg <= (fire != 8'h00) ||
                 (control_reg[uhps_pkg::POS_BUSY_IRQ_EN] &&
                  (is_in ? (busy_reg == 2'h0) : (busy_reg == nbanks)));
    end
  end

  assign fire = flags_reg & control_reg[7:0];

  // ----------------------------------------
  // Link outputs
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      zlp_reg <= 1'b0;
      drop_reg <= 1'b0;
      ackp_reg <= 1'b0;
    end else begin
      tx_data_reg <= rdata;
      tx_valid_reg <= link_pop;
      zlp_reg <= !is_in && iso_or_intr && i_link_out_slot && busy_reg == 2'h0;
      drop_reg <= is_in && iso_or_intr && i_link_pkt_start && busy_reg >= nbanks;
      ackp_reg <= is_in && (pipe_type == uhps_pkg::TYPE_INTR) && i_link_pkt_start && busy_reg >= nbanks;
    end
  end

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      rdat_reg <= 32'h0000_0000;
      if (bus_rd) begin
        unique case (i_wb_adr)
          uhps_pkg::ADDR_CONFIG: rdat_reg <= config_reg;
          uhps_pkg::ADDR_CONTROL: rdat_reg <= {control_reg[31:18], frozen_reg, control_reg[16:0]};
          uhps_pkg::ADDR_STATUS: rdat_reg <= {1'b0, byte_count_reg, 1'b0, config_ok_reg, 1'b0, rw_allowed_reg,
                                              cur_bank_reg, busy_reg, 2'h0, toggle_reg[rbank_reg], flags_reg};
          uhps_pkg::ADDR_FIFO: rdat_reg <= {24'h000000, rdata};
          uhps_pkg::ADDR_FAULT_SRC: rdat_reg <= {24'h000000, fault_src_reg};
          uhps_pkg::ADDR_IRQ: rdat_reg <= {31'h00000000, irq_reg};
          default: rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_wb_dat = rdat_reg;
  assign o_wb_ack = ack_reg;
  assign o_link_tx_data = tx_data_reg;
  assign o_link_tx_valid = tx_valid_reg;
  assign o_link_send_zlp = zlp_reg;
  assign o_link_drop_pkt = drop_reg;
  assign o_link_ack_pkt = ackp_reg;
  assign o_pipe_frozen = frozen_reg;
  assign o_pipe_irq = irq_reg;
endmodule

// >>> uhps_pipe_status_chk.sv
// Assertion checker bound to the pipe status block
`timescale 1ns/1ns
module uhps_pipe_status_chk (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Link side
  input wire logic i_link_tx_req,
  input wire logic i_link_out_slot,
  input wire logic i_link_stall,
  input wire logic i_link_nak,
  input wire logic o_link_tx_valid,
  input wire logic o_link_send_zlp,
  input wire logic o_link_drop_pkt,
  input wire logic o_link_ack_pkt,
  input wire logic o_pipe_frozen,
  input wire logic o_pipe_irq
);
  logic take;
  logic rd_sta_reg;
  logic nak_en_reg;
  logic [1:0] type_reg;
  assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // Shadow of pipe type and enables
  // ----------------------------------------
  // The checker cannot see the registers, so it tracks the writes itself
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_sta_reg <= 1'b0;
    end else begin
      rd_sta_reg <= take & ~i_wb_we & (i_wb_adr == uhps_pkg::ADDR_STATUS);
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      type_reg <= 2'h0;
      nak_en_reg <= 1'b0;
    end else if (take & i_wb_we) begin
      if (i_wb_adr == uhps_pkg::ADDR_CONFIG) begin
        type_reg <= i_wb_dat[13:12];
      end
      if (i_wb_adr == uhps_pkg::ADDR_CONTROL) begin
        nak_en_reg <= i_wb_dat[4];
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ack_once;
    take |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus ack is not one pulse after request");
  property p_tx_cause;
    o_link_tx_valid |-> $past(i_link_tx_req);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("byte sent without a link request");
  property p_zlp_cause;
    o_link_send_zlp |-> $past(i_link_out_slot) && type_reg[0];
  endproperty
  a_zlp_cause: assert property (p_zlp_cause) else $error("empty packet outside a periodic slot");
  property p_drop_type;
    o_link_drop_pkt || o_link_ack_pkt |-> type_reg[0];
  endproperty
  a_drop_type: assert property (p_drop_type) else $error("packet dropped on a non periodic pipe");
  property p_ack_intr;
    o_link_ack_pkt |-> type_reg == uhps_pkg::TYPE_INTR;
  endproperty
  a_ack_intr: assert property (p_ack_intr) else $error("dropped packet acked off an interrupt pipe");
  property p_stall_freeze;
    i_link_stall && type_reg != uhps_pkg::TYPE_ISO |-> ##[1:2] o_pipe_frozen;
  endproperty
  a_stall_freeze: assert property (p_stall_freeze) else $error("pipe not frozen after stall");
  property p_nak_irq;
    i_link_nak && nak_en_reg |-> ##[1:3] o_pipe_irq;
  endproperty
  a_nak_irq: assert property (p_nak_irq) else $error("no interrupt after enabled nak");
  property p_code_rsvd;
    o_wb_ack && rd_sta_reg |-> o_wb_dat[15:14] != 2'h3 && o_wb_dat[13:12] != 2'h3;
  endproperty
  a_code_rsvd: assert property (p_code_rsvd) else $error("reserved bank code read");
  property p_toggle_code;
    o_wb_ack && rd_sta_reg |-> !o_wb_dat[9];
  endproperty
  a_toggle_code: assert property (p_toggle_code) else $error("reserved toggle code read");
endmodule
bind uhps_pipe_status uhps_pipe_status_chk chk (.*);

// >>> uhps_pipe_status_tb_top.sv
// Testbench for the pipe status block
`timescale 1ns/1ns
module uhps_pipe_status_tb_top;
  logic i_clk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_link_tx_valid;
  logic [7:0] i_wb_adr, i_link_rx_data, o_link_tx_data;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic i_link_rx_valid, i_link_tx_req, i_link_pkt_end, i_link_pkt_pid1, i_link_pkt_start;
  logic o_link_send_zlp, o_link_drop_pkt, o_link_ack_pkt, o_pipe_frozen, o_pipe_irq;
  logic [4:0] evt;
  logic [8:0] b;
  int err_count, tests_run;
  uhps_pipe_status dut (.i_clk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .i_link_rx_valid, .i_link_rx_data, .i_link_tx_req, .o_link_tx_data, .o_link_tx_valid,
    .i_link_pkt_end, .i_link_pkt_pid1, .i_link_pkt_start, .i_link_out_slot(evt[0]), .i_link_stall(evt[1]),
    .i_link_nak(evt[2]), .i_link_crc_err(evt[3]), .i_link_fault(evt[4]), .o_link_send_zlp, .o_link_drop_pkt,
    .o_link_ack_pkt, .o_pipe_frozen, .o_pipe_irq);
  uhps_link_model link (.i_clk, .o_rx_valid(i_link_rx_valid), .o_rx_data(i_link_rx_data),
    .o_pkt_start(i_link_pkt_start), .o_pkt_end(i_link_pkt_end), .o_pid1(i_link_pkt_pid1),
    .o_tx_req(i_link_tx_req), .o_evt(evt), .i_tx_data(o_link_tx_data), .i_tx_valid(o_link_tx_valid));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 16);
    q = o_wb_dat;
    if (o_wb_ack !== 1'b1) begin
      err_count++;
      finish_test;
    end
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd_st;
    repeat (2) @(posedge i_clk);
    wb(1'b0, uhps_pkg::ADDR_STATUS, 32'h0);
  endtask
  task automatic rst;
    i_sys_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {i_wb_cyc, i_wb_stb, i_wb_we} = 3'h0;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0;
    i_wb_sel = 4'hF;
    err_count = 0;
    tests_run = 0;
    rst;
    rd_st;
    chk("status", q, uhps_pkg::STATUS_RESET);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    wb(1'b1, uhps_pkg::ADDR_CONFIG, 32'h227E);
    rd_st;
    chk("cfg_ok", q[18], 1'h0);
    wb(1'b1, uhps_pkg::ADDR_CONFIG, 32'h2278);
    wb(1'b1, uhps_pkg::ADDR_CONFIG, 32'h220A);
    rd_st;
    chk("cfg_ok", q[18], 1'h1);
    chk("rw", q[16], 1'h1);
    chk("toggle", q[9:8], 2'h0);
    chk("out_free", q[1], 1'h1);
    for (int k = 1; k < 9; k++) begin
      wb(1'b1, uhps_pkg::ADDR_FIFO, 32'h11 * k);
    end
    rd_st;
    chk("count", q[30:20], 11'h8);
    link.take_byte(b);
    chk("tx", b, 9'h111);
    rd_st;
    chk("count", q[30:20], 11'h7);
    $display("test out done");
    link.evt(5'h02);
    rd_st;
    chk("stall", q[6], 1'h1);
    chk("rw", q[16], 1'h0);
    chk("frozen", o_pipe_frozen, 1'h1);
    wb(1'b1, uhps_pkg::ADDR_STATUS_CLR, 32'h0);
    rd_st;
    chk("stall", q[6], 1'h1);
    wb(1'b1, uhps_pkg::ADDR_STATUS_CLR, 32'h40);
    rd_st;
    chk("stall", q[6], 1'h0);
    wb(1'b1, uhps_pkg::ADDR_CONTROL, 32'h10);
    link.evt(5'h04);
    rd_st;
    chk("nak", q[4], 1'h1);
    chk("irq", o_pipe_irq, 1'h1);
    wb(1'b1, uhps_pkg::ADDR_STATUS_CLR, 32'h10);
    rd_st;
    chk("irq", o_pipe_irq, 1'h0);
    link.evt(5'h10);
    rd_st;
    chk("fault", q[3], 1'h1);
    chk("rw", q[16], 1'h0);
    wb(1'b1, uhps_pkg::ADDR_STATUS_CLR, 32'h08);
    rd_st;
    chk("fault", q[3], 1'h1);
    wb(1'b1, uhps_pkg::ADDR_FAULT_SRC, 32'h0);
    rd_st;
    chk("fault", q[3], 1'h0);
    $display("test flags done");
    rst;
    wb(1'b1, uhps_pkg::ADDR_CONFIG, 32'h217A);
    link.send_in(2, 1'b1);
    rd_st;
    chk("count", q[30:20], 11'h2);
    chk("rw", q[16], 1'h1);
    chk("toggle", q[9:8], 2'h1);
    chk("short", q[7], 1'h1);
    wb(1'b0, uhps_pkg::ADDR_FIFO, 32'h0);
    chk("fifo", q[7:0], 8'hA0);
    rd_st;
    chk("count", q[30:20], 11'h1);
    wb(1'b1, uhps_pkg::ADDR_STATUS_CLR, 32'h80);
    rd_st;
    chk("short", q[7], 1'h0);
    $display("test in done");
    rst;
    wb(1'b1, uhps_pkg::ADDR_CONFIG, 32'h127A);
    link.evt(5'h01);
    rd_st;
    chk("underrun", q[2], 1'h1);
    link.evt(5'h08);
    rd_st;
    chk("crc", q[6], 1'h1);
    wb(1'b1, uhps_pkg::ADDR_STATUS_CLR, 32'h44);
    rd_st;
    chk("crc", {q[6], q[2]}, 2'h0);
    rst;
    wb(1'b1, uhps_pkg::ADDR_CONFIG, 32'h3172);
    link.send_in(1, 1'b0);
    link.send_in(1, 1'b1);
    rd_st;
    chk("underrun", q[2], 1'h1);
    $display("test periodic done");
    finish_test;
  end
endmodule

// >>> uhps_pkg.sv
// Package: register map, field positions and encodings for the pipe status block
package uhps_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_STATUS_CLR = 8'h0C;
  localparam logic [7:0] ADDR_STATUS_SET = 8'h10;
  localparam logic [7:0] ADDR_FIFO = 8'h14;
  localparam logic [7:0] ADDR_FAULT_SRC = 8'h18;
  localparam logic [7:0] ADDR_IRQ = 8'h1C;
  // ----------------------------------------
  // Status bit positions, then the busy irq enable bit of control
  // ----------------------------------------
  localparam int BIT_RXIN = 0;
  localparam int BIT_OUTFREE = 1;
  localparam int BIT_SETUP_UNDER = 2;
  localparam int BIT_FAULT = 3;
  localparam int BIT_NAK = 4;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_STALL_CRC = 6;
  localparam int BIT_SHORT = 7;
  localparam int POS_DATA_TOGGLE_SEQ = 8;
  localparam int POS_BUSY = 12;
  localparam int POS_CURBANK = 14;
  localparam int POS_RW_ALLOWED = 16;
  localparam int POS_CONFIG_OK = 18;
  localparam int POS_BYTECNT = 20;
  localparam int POS_BUSY_IRQ_EN = 12;
  // ----------------------------------------
  // Config field positions
  // ----------------------------------------
  localparam int POS_PIPE_MEM_ALLOCATE = 1;
  localparam int POS_BANKS = 2;
  localparam int POS_SIZE = 4;
  localparam int POS_TOKEN = 8;
  localparam int POS_TYPE = 12;
  // ----------------------------------------
  // Encodings and sizes
  // ----------------------------------------
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] TYPE_ISO = 2'h1;
  localparam logic [1:0] TYPE_INTR = 2'h3;
  localparam logic [1:0] TOKEN_IN = 2'h1;
  localparam logic [1:0] MAX_BANKS_SEL = 2'h2;
  localparam logic [2:0] MAX_SIZE_SEL = 3'h7;
  localparam logic [12:0] RAM_BYTES = 13'h1000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam int BANK_DEPTH = 1024;
  localparam int BANKS = 3;
  typedef enum logic [1:0] {UHPS_TOK_SETUP, UHPS_TOK_IN, UHPS_TOK_OUT, UHPS_TOK_RSVD} uhps_token_t;
endpackage
